// [eti_irq_flags.sv]
// Purpose : Request flags and vector request for pin A, pin B, timer 0 and timer 1
// Assumes : One clock; pins asynchronous; timer overflow and CPU strobes synchronous
// Notes   : Vector request is a level held until the CPU takes the vector
//
// The AXI4-Lite interface to the registers is this design's own decision.

`timescale 1ns/1ps
`default_nettype none

module eti_irq_flags (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    // AXI4-Lite slave
    input  wire logic [eti_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [eti_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Pins and events
    input  wire logic                     extIrqA,
    input  wire logic                     extIrqB,
    input  wire logic                     timer0Overflow,
    input  wire logic                     timer1Overflow,
    input  wire logic                     powerDownMode,
    input  wire logic                     greenMode,
    // CPU sequencer side
    input  wire logic                     cpuVectorTaken,
    input  wire logic                     cpuServiceReturn,
    output logic                          vectorReq,
    output logic [15:0]                   vectorAddr,
    output logic                          wakeReq
);

    // =====================================================================
    // Pin synchronisers and edge detection
    // =====================================================================
    logic [1:0] pinMeta_q;
    logic [1:0] pinSync_q;
    logic [1:0] pinPrev_q;

    // Two stages before any logic; edge detect compares the second stage with its delayed copy pinPrev_q
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pinMeta_q <= 2'b00;
            pinSync_q <= 2'b00;
            pinPrev_q <= 2'b00;
        end else begin
            pinMeta_q <= {extIrqB, extIrqA};
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // =====================================================================
    // Registers
    // =====================================================================
    logic [7:0] edgeSel_q;
    logic [7:0] reqFlag_q;
    logic [7:0] irqEn_q;
    logic       gie_q;
    logic [1:0] edgeSelField;
    logic       riseA;
    logic       fallA;
    logic       fallB;
    logic       trigA;
    logic [7:0] hwSet;
    logic       doWrite;
    logic [eti_pkg::ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        awHave_q;
    logic        wHave_q;
    logic        wrByte0;
    logic        pending;
    logic        awake;

    assign edgeSelField = edgeSel_q[eti_pkg::EDGE_LSB +: 2];
    assign riseA = pinSync_q[0] && !pinPrev_q[0];
    assign fallA = !pinSync_q[0] && pinPrev_q[0];
    assign fallB = !pinSync_q[1] && pinPrev_q[1];

    // Reserved code triggers nothing
    always_comb begin
        case (edgeSelField)
            eti_pkg::EDGE_RISING:  trigA = riseA;
            eti_pkg::EDGE_FALLING: trigA = fallA;
            eti_pkg::EDGE_BOTH:    trigA = riseA || fallA;
            default:               trigA = 1'b0;
        endcase
    end

    // Hardware set vector, independent of enables
    always_comb begin
        hwSet = 8'h00;
        hwSet[eti_pkg::BIT_PIN_A]  = trigA;
        hwSet[eti_pkg::BIT_PIN_B]  = fallB;
        hwSet[eti_pkg::BIT_TIMER0] = timer0Overflow;
        hwSet[eti_pkg::BIT_TIMER1] = timer1Overflow;
    end

    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    assign wrByte0 = doWrite && wStrb_q[0];

    // Edge select and enable registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            edgeSel_q <= eti_pkg::RST_EDGE_SEL;
            irqEn_q   <= eti_pkg::RST_IRQ_EN;
        end else if (wrByte0) begin
            if (awAddr_q == eti_pkg::ADDR_EDGE_SEL)
                edgeSel_q <= wData_q[7:0] & eti_pkg::EDGE_MASK;
            if (awAddr_q == eti_pkg::ADDR_IRQ_EN)
                irqEn_q <= wData_q[7:0] & eti_pkg::SRC_MASK;
        end
    end

    // Flags only clear by software; a set in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reqFlag_q <= eti_pkg::RST_REQ_FLAG;
        end else if (wrByte0 && awAddr_q == eti_pkg::ADDR_REQ_FLAG) begin
            reqFlag_q <= (wData_q[7:0] | hwSet) & eti_pkg::SRC_MASK;
        end else begin
            reqFlag_q <= reqFlag_q | hwSet;
        end
    end

    // Global enable: CPU entry/return outrank a software write
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            gie_q <= eti_pkg::RST_GIE;
        end else if (cpuVectorTaken && vectorReq) begin
            gie_q <= 1'b0;
        end else if (cpuServiceReturn) begin
            gie_q <= 1'b1;
        end else if (wrByte0 && awAddr_q == eti_pkg::ADDR_GLOBAL) begin
            gie_q <= wData_q[eti_pkg::BIT_GIE];
        end
    end

    // =====================================================================
    // Vector request and wake-up
    // =====================================================================
    assign pending = |(reqFlag_q & irqEn_q);
    assign awake   = !powerDownMode && !greenMode;

    // Latched flags request service once awake
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            vectorReq  <= 1'b0;
            vectorAddr <= eti_pkg::VECTOR_ADDR;
        end else begin
            vectorReq  <= gie_q && pending && awake && !cpuVectorTaken;
            vectorAddr <= eti_pkg::VECTOR_ADDR;
        end
    end

    // Wake pulse for a pin A edge in power-down, or a pin B fall in power-down or green mode
    always_ff @(posedge sys_clk) begin
        if (!resetn)
            wakeReq <= 1'b0;
        else
            wakeReq <= (powerDownMode && trigA)
                    || ((powerDownMode || greenMode) && fallB);
    end

    // =====================================================================
    // AXI4-Lite write channel
    // =====================================================================
    // Address and data taken in either order; one write outstanding
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            awHave_q      <= 1'b0;
            wHave_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[eti_pkg::ADDR_W-1:2], 2'b00};
            end else if (doWrite) begin
                awHave_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHave_q <= 1'b0;
            end
            s_axi_awready <= !awHave_q && !s_axi_bvalid && !doWrite
                          && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHave_q && !s_axi_bvalid && !doWrite
                          && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= eti_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == eti_pkg::ADDR_EDGE_SEL || awAddr_q == eti_pkg::ADDR_REQ_FLAG
                          || awAddr_q == eti_pkg::ADDR_IRQ_EN || awAddr_q == eti_pkg::ADDR_GLOBAL)
                          ? eti_pkg::RESP_OKAY : eti_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // =====================================================================
    // AXI4-Lite read channel
    // =====================================================================
    logic [eti_pkg::ADDR_W-1:0] rdAddr;
    assign rdAddr = {s_axi_araddr[eti_pkg::ADDR_W-1:2], 2'b00};

    // Single read outstanding; data shows live flag and enable state
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= eti_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= eti_pkg::RESP_OKAY;
                case (rdAddr)
                    eti_pkg::ADDR_EDGE_SEL: s_axi_rdata <= {24'h00_0000, edgeSel_q};
                    eti_pkg::ADDR_REQ_FLAG: s_axi_rdata <= {24'h00_0000, reqFlag_q};
                    eti_pkg::ADDR_IRQ_EN:   s_axi_rdata <= {24'h00_0000, irqEn_q};
                    eti_pkg::ADDR_GLOBAL:   s_axi_rdata <= {24'h00_0000, gie_q, 7'h00};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= eti_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_pin_a_set;
        trigA |=> reqFlag_q[eti_pkg::BIT_PIN_A];
    endproperty
    a_pin_a_set: assert property (p_pin_a_set) else $error("pin A edge did not set flag");

    property p_edge_rsvd;
        edgeSelField == eti_pkg::EDGE_RSVD |-> !trigA;
    endproperty
    a_edge_rsvd: assert property (p_edge_rsvd) else $error("reserved edge code triggered");

    property p_pin_b_set;
        (pinSync_q[1] ##1 !pinSync_q[1]) |=> reqFlag_q[eti_pkg::BIT_PIN_B];
    endproperty
    a_pin_b_set: assert property (p_pin_b_set) else $error("pin B fall did not set flag");

    property p_pin_b_no_rise;
        (!pinPrev_q[1] && pinSync_q[1]) |-> !hwSet[eti_pkg::BIT_PIN_B];
    endproperty
    a_pin_b_no_rise: assert property (p_pin_b_no_rise) else $error("pin B rise triggered");

    property p_timers_set;
        (timer0Overflow || timer1Overflow) |=>
            ((reqFlag_q[eti_pkg::BIT_TIMER0] || !$past(timer0Overflow))
             && (reqFlag_q[eti_pkg::BIT_TIMER1] || !$past(timer1Overflow)));
    endproperty
    a_timers_set: assert property (p_timers_set) else $error("timer overflow lost");

    property p_vec_cause;
        $rose(vectorReq) |-> $past(gie_q) && $past(pending) && $past(awake);
    endproperty
    a_vec_cause: assert property (p_vec_cause) else $error("vector without cause");

    property p_vec_raise;
        gie_q && pending && awake && !cpuVectorTaken |=> vectorReq && vectorAddr == 16'h0008;
    endproperty
    a_vec_raise: assert property (p_vec_raise) else $error("enabled request not vectored");

    property p_disabled_quiet;
        !gie_q || !pending |=> !vectorReq;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source vectored");

    sequence s_entry;
        vectorReq && cpuVectorTaken;
    endsequence
    sequence s_blocked;
        !gie_q ##1 !vectorReq;
    endsequence
    property p_entry;
        s_entry |=> s_blocked;
    endproperty
    a_entry: assert property (p_entry) else $error("entry left global enable set");

    property p_return;
        cpuServiceReturn && !(vectorReq && cpuVectorTaken) |=> gie_q;
    endproperty
    a_return: assert property (p_return) else $error("return did not restore enable");

    sequence s_sleep_edge;
        powerDownMode && trigA;
    endsequence
    property p_wake_a;
        s_sleep_edge |=> wakeReq && reqFlag_q[eti_pkg::BIT_PIN_A];
    endproperty
    a_wake_a: assert property (p_wake_a) else $error("sleep edge not latched");

    property p_wake_b;
        (powerDownMode || greenMode) && fallB |=> wakeReq && reqFlag_q[eti_pkg::BIT_PIN_B];
    endproperty
    a_wake_b: assert property (p_wake_b) else $error("pin B wake not latched");

    property p_set_wins;
        (wrByte0 && awAddr_q == eti_pkg::ADDR_REQ_FLAG && hwSet != 8'h00)
            |=> (reqFlag_q & $past(hwSet)) == $past(hwSet);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

endmodule : eti_irq_flags

`default_nettype wire

// [eti_pkg.sv]
// Purpose : Shared constants for the external pin and timer request flag block
// Assumes : 32-bit AXI4-Lite register access, word aligned
// Notes   : Byte address is four times the register index

package eti_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0]  IDX_EDGE_SEL = 8'hBF;  // ext_edge_select
    localparam logic [7:0]  IDX_REQ_FLAG = 8'hC8;  // request flags
    localparam logic [7:0]  IDX_IRQ_EN   = 8'hC9;  // source enables
    localparam logic [7:0]  IDX_GLOBAL   = 8'hDF;  // global enable
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] ADDR_EDGE_SEL = {2'b00, IDX_EDGE_SEL, 2'b00};
    localparam logic [11:0] ADDR_REQ_FLAG = {2'b00, IDX_REQ_FLAG, 2'b00};
    localparam logic [11:0] ADDR_IRQ_EN   = {2'b00, IDX_IRQ_EN, 2'b00};
    localparam logic [11:0] ADDR_GLOBAL   = {2'b00, IDX_GLOBAL, 2'b00};

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int BIT_PIN_A   = 0;
    localparam int BIT_PIN_B   = 1;
    localparam int BIT_TIMER0  = 5;
    localparam int BIT_TIMER1  = 6;
    localparam int BIT_GIE     = 7;
    localparam int EDGE_LSB    = 3;
    localparam logic [7:0] SRC_MASK  = 8'h63;  // Implemented flag/enable bits
    localparam logic [7:0] EDGE_MASK = 8'h18;  // edge_sel_field bits 4:3

    // =====================================================================
    // Edge codes and reset values
    // =====================================================================
    typedef enum logic [1:0] {
        EDGE_RSVD    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } eti_edge_t;

    localparam logic [7:0]  RST_EDGE_SEL = 8'h10;  // Falling edge
    localparam logic [7:0]  RST_REQ_FLAG = 8'h00;
    localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
    localparam logic        RST_GIE      = 1'b0;
    localparam logic [15:0] VECTOR_ADDR  = 16'h0008;

    // =====================================================================
    // AXI responses
    // =====================================================================
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : eti_pkg

// [eti_cpu_model.sv]
// Purpose : Behavioural CPU sequencer that takes the vector and later returns
// Assumes : vectorReq is a level held until cpuVectorTaken is seen
// Notes   : Fixed service span

`timescale 1ns/1ps
`default_nettype none

module eti_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        vectorReq,
    input  wire logic [15:0] vectorAddr,
    input  wire logic [3:0]  takeDelay,
    output logic             cpuVectorTaken,
    output logic             cpuServiceReturn,
    output logic [7:0]       vecCount,
    output logic [7:0]       badVector
);
    // =====================================================================
    // Sequencer
    // =====================================================================
    logic [1:0] state;
    logic [5:0] cnt;

    // Take after a chosen delay, serve a fixed span, then return
    always_ff @(posedge sys_clk) begin
        cpuVectorTaken   <= 1'b0;
        cpuServiceReturn <= 1'b0;
        if (!resetn) begin
            state     <= 2'h0;
            cnt       <= 6'h00;
            vecCount  <= 8'h00;
            badVector <= 8'h00;
        end else if (state == 2'h0 && vectorReq) begin
            state <= 2'h1;
            cnt   <= {2'h0, takeDelay};  // Prompt or slow take
        end else if (state == 2'h1 && cnt == 6'h00) begin
            cpuVectorTaken <= 1'b1;
            state          <= 2'h2;
            cnt            <= 6'h28;
            vecCount       <= vecCount + 8'h01;
            if (vectorAddr !== eti_pkg::VECTOR_ADDR) begin
                badVector <= badVector + 8'h01;
            end
        end else if (state == 2'h2 && cnt == 6'h00) begin
            cpuServiceReturn <= 1'b1;  // Service exit restores global enable
            state            <= 2'h0;
        end else if (state != 2'h0) begin
            cnt <= cnt - 6'h01;
        end
    end

endmodule : eti_cpu_model

`default_nettype wire

// [eti_irq_flags_test.sv]
// Purpose : Self-checking bench for the request flag and vector block
// Assumes : AXI4-Lite tasks; CPU is a model
// Notes   : Random values from an xorshift seeded with 99

`timescale 1ns/1ps
`default_nettype none

module eti_irq_flags_test;
    // =====================================================================
    // Signals
    // =====================================================================
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        extIrqA = 1'b0;
    logic        extIrqB = 1'b1;
    logic        timer0Overflow = 1'b0;
    logic        timer1Overflow = 1'b0;
    logic        powerDownMode = 1'b0;
    logic        greenMode = 1'b0;
    logic [3:0]  takeDelay = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        cpuVectorTaken, cpuServiceReturn, vectorReq, wakeReq;
    logic [15:0] vectorAddr;
    logic [7:0]  vecCount, badVector;
    logic [31:0] seed = 32'h0000_0063;
    int          n_fail = 0;
    int          comparisons = 0;
    int          wakeCount = 0;

    eti_irq_flags uut (
        .sys_clk(sys_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .extIrqA(extIrqA), .extIrqB(extIrqB), .timer0Overflow(timer0Overflow),
        .timer1Overflow(timer1Overflow), .powerDownMode(powerDownMode), .greenMode(greenMode),
        .cpuVectorTaken(cpuVectorTaken), .cpuServiceReturn(cpuServiceReturn),
        .vectorReq(vectorReq), .vectorAddr(vectorAddr), .wakeReq(wakeReq)
    );

    eti_cpu_model cpu (
        .sys_clk(sys_clk), .resetn(resetn), .vectorReq(vectorReq), .vectorAddr(vectorAddr),
        .takeDelay(takeDelay), .cpuVectorTaken(cpuVectorTaken),
        .cpuServiceReturn(cpuServiceReturn), .vecCount(vecCount), .badVector(badVector)
    );

    // =====================================================================
    // Clock, wake counter, watchdog
    // =====================================================================
    always #5 sys_clk = ~sys_clk;

    // Count one-cycle wake pulses
    always @(posedge sys_clk) begin
        if (wakeReq === 1'b1) wakeCount <= wakeCount + 1;
    end

    // Run is under a thousand cycles; watchdog at 20000
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end

    // =====================================================================
    // Helpers
    // =====================================================================
    function logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nextRand

    // Pin A flag expected for an edge code and direction
    function logic [31:0] expA(input int code, input logic rising);
        return {31'h0, code == 3 || (rising ? code == 1 : code == 2)};
    endfunction : expA

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Address and data offered together, each released once taken
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask : axiWr

    task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axiRd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axiWr(a, d, r);
        chk({30'h0, r}, {30'h0, eti_pkg::RESP_OKAY});
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axiRd(a, d, r);
        chk(d, e);
    endtask : rdChk

    // One event, then time to synchronise
    task automatic fire(input int b);
        if (b == 0) extIrqA <= ~extIrqA;
        if (b == 1) extIrqB <= ~extIrqB;
        timer0Overflow <= (b == 5);
        timer1Overflow <= (b == 6);
        @(posedge sys_clk);
        timer0Overflow <= 1'b0;
        timer1Overflow <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : fire

    // Low-power edge: latched, serviced after wake
    task automatic lowPower(input int b, input logic green);
        logic [7:0] v;
        int         w;
        wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0001 << b);
        v = vecCount;
        w = wakeCount;
        if (green) greenMode <= 1'b1;
        else powerDownMode <= 1'b1;
        @(posedge sys_clk);
        if ((b == 0 ? extIrqA : extIrqB) == 1'b0) fire(b);
        fire(b);
        chk(32'(wakeCount - w), 32'h0000_0001);
        chk(32'(vecCount), 32'(v));
        powerDownMode <= 1'b0;
        greenMode     <= 1'b0;
        repeat (14) @(posedge sys_clk);
        chk(32'(vecCount), 32'(v) + 32'h0000_0001);
        wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        repeat (50) @(posedge sys_clk);
    endtask : lowPower

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        logic [31:0] d;
        logic [31:0] r32;
        logic [1:0]  r;
        logic [7:0]  v;
        int          srcs [4];
        srcs = '{0, 1, 5, 6};
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // Reset values, unmapped, no strobe
        rdChk(eti_pkg::ADDR_EDGE_SEL, 32'h0000_0010);
        rdChk(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        rdChk(eti_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        rdChk(eti_pkg::ADDR_GLOBAL, 32'h0000_0000);
        axiWr(12'h000, 32'h0000_00FF, r);
        chk({30'h0, r}, {30'h0, eti_pkg::RESP_SLVERR});
        axiRd(12'h000, d, r);
        chk(d, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, eti_pkg::RESP_SLVERR});
        s_axi_wstrb <= 4'h0;
        wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0063);
        s_axi_wstrb <= 4'hF;
        rdChk(eti_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        // Random register traffic while globally disabled
        repeat (4) begin
            r32 = nextRand();
            wr(eti_pkg::ADDR_IRQ_EN, r32);
            rdChk(eti_pkg::ADDR_IRQ_EN, r32 & 32'(eti_pkg::SRC_MASK));
            wr(eti_pkg::ADDR_REQ_FLAG, r32);
            rdChk(eti_pkg::ADDR_REQ_FLAG, r32 & 32'(eti_pkg::SRC_MASK));
            wr(eti_pkg::ADDR_EDGE_SEL, r32);
            rdChk(eti_pkg::ADDR_EDGE_SEL, r32 & 32'(eti_pkg::EDGE_MASK));
        end
        wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        wr(eti_pkg::ADDR_GLOBAL, 32'h0000_0080);
        // Every edge code, both directions on pin A, enables off
        for (int c = 0; c < 4; c++) begin
            wr(eti_pkg::ADDR_EDGE_SEL, 32'(c) << 3);
            fire(0);
            rdChk(eti_pkg::ADDR_REQ_FLAG, expA(c, 1'b1));
            wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
            fire(0);
            rdChk(eti_pkg::ADDR_REQ_FLAG, expA(c, 1'b0));
            wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        end
        // Pin B direction, then timers, all with enables off
        fire(1);
        rdChk(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0002);
        wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        fire(1);
        rdChk(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        fire(5);
        fire(6);
        rdChk(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0060);
        chk(32'(vecCount), 32'h0000_0000);
        wr(eti_pkg::ADDR_GLOBAL, 32'h0000_0000);
        wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0063);
        repeat (10) @(posedge sys_clk);
        chk(32'(vecCount), 32'h0000_0000);
        wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
        wr(eti_pkg::ADDR_EDGE_SEL, 32'h0000_0018);
        // Each enabled source vectors once
        foreach (srcs[i]) begin
            r32 = nextRand();
            takeDelay <= {1'b0, r32[2:0]};
            v = vecCount;
            wr(eti_pkg::ADDR_IRQ_EN, 32'h0000_0001 << srcs[i]);
            wr(eti_pkg::ADDR_GLOBAL, 32'h0000_0080);
            fire(srcs[i]);
            repeat (12) @(posedge sys_clk);
            chk(32'(vecCount), 32'(v) + 32'h0000_0001);
            rdChk(eti_pkg::ADDR_GLOBAL, 32'h0000_0000);
            wr(eti_pkg::ADDR_REQ_FLAG, 32'h0000_0000);
            repeat (50) @(posedge sys_clk);
            rdChk(eti_pkg::ADDR_GLOBAL, 32'h0000_0080);
            chk(32'(vecCount), 32'(v) + 32'h0000_0001);
        end
        wr(eti_pkg::ADDR_EDGE_SEL, 32'h0000_0010);
        lowPower(0, 1'b0);
        lowPower(1, 1'b1);
        chk(32'(badVector), 32'h0000_0000);
        finish_test();
    end

endmodule : eti_irq_flags_test

`default_nettype wire
